// >>> gpio_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_chk_asserts (
  input wire SYS_CLK,
  input wire RST,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [39:0] GPIO_IN,
  input wire [39:0] GPIO_OUT,
  input wire [39:0] GPIO_OE,
  input wire [39:0] GPIO_PULLUP,
  input wire IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [39:0] q; // Last pads
  logic [5:0] eh; // Recent pin events or writes
  logic [3:0] bh; // Recent bus answers
  // Short histories so an IRQ edge can be traced to its cause
  always @(posedge SYS_CLK)
  begin
    q <= GPIO_IN;
    eh <= {eh[4:0], (|((GPIO_IN ^ q) & 40'hFF0000DFFF)) | S_AXI_BVALID};
    bh <= {bh[2:0], S_AXI_RVALID | S_AXI_BVALID};
  end
  a_reset_low_drive: assert property ($fell(RST) |-> GPIO_OE[13] && !GPIO_OUT[13])
    else $error("b1b5 reset");
  a_out_only_on: assert property (GPIO_OE[13])
    else $error("b1b5 off");
  a_bank3_absent: assert property (GPIO_OE[31:29] == 3'h0 && GPIO_PULLUP[31:29] == 3'h0)
    else $error("b3 bits");
  a_irq_rise_cause: assert property ($rose(IRQ) |-> |eh || S_AXI_BVALID)
    else $error("irq rise");
  a_irq_fall_cause: assert property ($fell(IRQ) |-> |bh || S_AXI_RVALID || S_AXI_BVALID)
    else $error("irq fall");
  a_bvalid_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("b drop");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA))
    else $error("r change");
  a_rdata_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("r upper");
endmodule // gpio_chk_asserts
bind gpio_ports_five_banks gpio_chk_asserts i_chk (.*);
`default_nettype wire

// >>> gpio_map.vh
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH
// Bank address shift and register offsets inside one bank (word numbers, address bits 4:2)
`define BANK_SHIFT 5
`define OFS_OUT 3'h0
`define OFS_DIR 3'h1
`define OFS_PULL 3'h2
`define OFS_OD 3'h3
`define OFS_IN 3'h4
`define OFS_MASK 3'h5
`define OFS_STAT 3'h6
// Number of registers per bank
`define REGS_PER_BANK 3'h7
// Implemented pins, bank 4 in the top byte
`define IMPL_PINS 40'hFF1FFFFFFF
// Pins able to raise interrupts (banks 0, 1 and 4)
`define IRQ_PINS 40'hFF0000FFFF
// Output-only pin: bank 1 bit 5
`define OUT_ONLY 40'h0000002000
// Reset values
`define RST_OUT 40'h0000000000
`define RST_DIR 40'h0000000000
`define RST_PULL 40'h0000000000
`define RST_OD 40'h0000000000
`define RST_MASK 40'h0000000000
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> gpio_pads.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pads (
  input wire logic [39:0] o,
  input wire logic [39:0] oe,
  input wire logic [39:0] ev,
  output logic [39:0] pad
);
  // Device wins where it drives; board level elsewhere, so no pin floats
  assign pad = (oe & o) | (~oe & ev);
endmodule // gpio_pads
`default_nettype wire

// >>> gpio_ports_five_banks.v
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_map.vh"

// What this block does
// - Each pin independently input or input/output
// - Per-pin static pull-up on or off
// - Per-pin open-drain or push-pull driver
// - Bank 0 interrupts, per-pin enable mask
// - Bank 1 like bank 0 except bit 5
// - Bank 1 bit 5 output only, low default
// - Bank 2 configurable, never interrupts
// - Bank 3 only bits 0 to 4
// - Bank 4 full config and interrupt mask
module gpio_ports_five_banks #(
  parameter ADDR_W = 8,
  parameter BANKS = 5
) (
  input wire SYS_CLK,
  input wire RST,
  input wire [ADDR_W-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [ADDR_W-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [BANKS*8-1:0] GPIO_IN,
  output reg [BANKS*8-1:0] GPIO_OUT,
  output reg [BANKS*8-1:0] GPIO_OE,
  output reg [BANKS*8-1:0] GPIO_PULLUP,
  output reg IRQ
);

  localparam W = BANKS*8;

  // Address is a known bank and register
  function addr_ok;
    input [ADDR_W-1:0] a;
    begin
      addr_ok = (a[ADDR_W-1:`BANK_SHIFT] < BANKS) &&
                (a[`BANK_SHIFT-1:2] < `REGS_PER_BANK) &&
                (a[1:0] == 2'h0);
    end
  endfunction

  // One bank's byte of a per-pin map; callers gate on addr_ok first
  function [7:0] bank_bits;
    input [W-1:0] pins;
    input [2:0] bank;
    begin
      bank_bits = pins[bank*8 +: 8];
    end
  endfunction

  // Configuration state, all banks side by side
  reg [W-1:0] out_r; // Output data
  reg [W-1:0] dir_r; // 1 = pin may drive
  reg [W-1:0] pull_r; // Pull-up enables
  reg [W-1:0] od_r; // 1 = open drain
  reg [W-1:0] mask_r; // Interrupt enables
  reg [W-1:0] stat_r; // Sticky change flags
  reg [W-1:0] stat_nxt;

  // Input synchroniser and change detector
  reg [W-1:0] sync1_r; // First stage, feeds sync2 only
  reg [W-1:0] sync2_r;
  reg [W-1:0] prev_r; // Previous settled value
  wire [W-1:0] change;
  wire [W-1:0] event_set;

  // Write channel holding registers
  reg aw_held_r;
  reg w_held_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg [7:0] w_data_r;
  reg w_lane_r; // Byte lane 0 enabled
  wire wr_go;
  wire [2:0] wr_bank;
  wire [2:0] wr_reg;

  // Read decode
  wire rd_go;
  wire [2:0] rd_bank;
  wire [2:0] rd_reg;
  wire rd_clr; // Read of a status register
  reg [7:0] rd_byte;

  // Effective pin configuration
  wire [W-1:0] dir_eff;
  wire [W-1:0] pin_in;

  // Two-stage capture of pad inputs
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sync1_r <= {W{1'b0}};
      sync2_r <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end
    else
    begin
      sync1_r <= GPIO_IN;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Any edge on a capable pin is an event; bank 2 and 3 never qualify
  assign change = sync2_r ^ prev_r;
  assign event_set = change & `IRQ_PINS & ~`OUT_ONLY;

  // Output-only pin is always set to output; absent pins never are
  assign dir_eff = (dir_r | `OUT_ONLY) & `IMPL_PINS;

  // Output-only pin has no input; absent pins read zero
  assign pin_in = sync2_r & `IMPL_PINS & ~`OUT_ONLY;

  // Write happens once address and data are both held
  assign wr_go = aw_held_r & w_held_r & ~S_AXI_BVALID;
  assign wr_bank = aw_addr_r[ADDR_W-1:`BANK_SHIFT];
  assign wr_reg = aw_addr_r[`BANK_SHIFT-1:2];

  // Write address and data, taken in either order
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      // Ready is a one-cycle accept pulse
      S_AXI_AWREADY <= S_AXI_AWVALID & ~aw_held_r & ~S_AXI_AWREADY;
      S_AXI_WREADY <= S_AXI_WVALID & ~w_held_r & ~S_AXI_WREADY;
      if (S_AXI_AWVALID & S_AXI_AWREADY)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (S_AXI_WVALID & S_AXI_WREADY)
      begin
        w_held_r <= 1'b1;
        w_data_r <= S_AXI_WDATA[7:0];
        w_lane_r <= S_AXI_WSTRB[0];
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // Write response
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      S_AXI_BVALID <= 1'b1;
      // Unknown address answers with an error
      S_AXI_BRESP <= addr_ok(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end

  // Configuration writes; only byte lane 0 carries data
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      out_r <= `RST_OUT;
      dir_r <= `RST_DIR;
      pull_r <= `RST_PULL;
      od_r <= `RST_OD;
      mask_r <= `RST_MASK;
    end
    else if (wr_go && w_lane_r && addr_ok(aw_addr_r))
    begin
      // Absent bits are masked off so they stay zero
      case (wr_reg)
        `OFS_OUT:
          out_r[wr_bank*8 +: 8] <= w_data_r & bank_bits(`IMPL_PINS, wr_bank);
        `OFS_DIR:
          dir_r[wr_bank*8 +: 8] <= w_data_r & bank_bits(`IMPL_PINS, wr_bank);
        `OFS_PULL:
          pull_r[wr_bank*8 +: 8] <= w_data_r & bank_bits(`IMPL_PINS, wr_bank);
        `OFS_OD:
          od_r[wr_bank*8 +: 8] <= w_data_r & bank_bits(`IMPL_PINS, wr_bank);
        `OFS_MASK:
          mask_r[wr_bank*8 +: 8] <= w_data_r & bank_bits(`IRQ_PINS, wr_bank);
        default:
          // Input and status registers ignore writes
          out_r <= out_r;
      endcase
    end
  end

  // Read address decode
  assign rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_bank = S_AXI_ARADDR[ADDR_W-1:`BANK_SHIFT];
  assign rd_reg = S_AXI_ARADDR[`BANK_SHIFT-1:2];
  assign rd_clr = rd_go & addr_ok(S_AXI_ARADDR) & (rd_reg == `OFS_STAT);

  // Read data selection
  always @*
  begin
    rd_byte = 8'h00;
    if (addr_ok(S_AXI_ARADDR))
    begin
      case (rd_reg)
        `OFS_OUT: rd_byte = out_r[rd_bank*8 +: 8];
        `OFS_DIR: rd_byte = dir_eff[rd_bank*8 +: 8];
        `OFS_PULL: rd_byte = pull_r[rd_bank*8 +: 8];
        `OFS_OD: rd_byte = od_r[rd_bank*8 +: 8];
        `OFS_IN: rd_byte = pin_in[rd_bank*8 +: 8];
        `OFS_MASK: rd_byte = mask_r[rd_bank*8 +: 8];
        `OFS_STAT: rd_byte = stat_r[rd_bank*8 +: 8];
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Read channel; one-cycle ready pulse, data registered
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
      if (rd_go)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h000000, rd_byte};
        S_AXI_RRESP <= addr_ok(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // Status: a read clears its bank, but a new event wins
  always @*
  begin
    stat_nxt = stat_r;
    if (rd_clr)
      stat_nxt[rd_bank*8 +: 8] = 8'h00;
    stat_nxt = stat_nxt | event_set;
  end

  // Status and interrupt line
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      stat_r <= {W{1'b0}};
      IRQ <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      // Level output from the next state so it tracks status exactly
      IRQ <= |(stat_nxt & mask_r);
    end
  end

  // Pad drivers, registered so every output comes from a flop
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      GPIO_OUT <= {W{1'b0}};
      GPIO_OE <= `OUT_ONLY;
      GPIO_PULLUP <= {W{1'b0}};
    end
    else
    begin
      // Open drain only ever drives low; high releases the pin
      GPIO_OUT <= out_r & ~od_r & dir_eff;
      GPIO_OE <= dir_eff & (~od_r | ~out_r);
      GPIO_PULLUP <= pull_r & `IMPL_PINS & ~`OUT_ONLY;
    end
  end

endmodule // gpio_ports_five_banks
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'h0, rst = 1'h1, aw = 1'h0, wv = 1'h0, br = 1'h0, ar = 1'h0, rr = 1'h0;
  logic [7:0] wa = 8'h0, ra = 8'h0, d;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0] r, bp, rp, bq;
  logic [3:0] ws = 4'hF; // Write strobes
  logic awr, wrd, bv, arr, rv, irq;
  logic [39:0] ev = 40'hFFFFFFFFFF; // Board drives every pin high
  wire [39:0] pin, po, poe, ppu;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  gpio_ports_five_banks i_gpio_ports_five_banks (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(wa),
    .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .GPIO_IN(pin), .GPIO_OUT(po), .GPIO_OE(poe), .GPIO_PULLUP(ppu), .IRQ(irq));
  gpio_pads i_gpio_pads (.o(po), .oe(poe), .ev(ev), .pad(pin));
  always #2.5 clk = ~clk;
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      num_errors++;
      tally_and_finish;
    end
  end
  function [7:0] adr(input int b, input int g);
    adr = {b[2:0], g[2:0], 2'h0};
  endfunction
  task chk(input [79:0] g, input [79:0] e);
  begin
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    logic pa, pw;
  begin
    pa = 1'h1;
    pw = 1'h1;
    wa <= a;
    wd <= {24'h0, v};
    aw <= 1'h1;
    wv <= 1'h1;
    while (pa | pw)
    begin
      @(posedge clk);
      if (awr === 1'h1) pa = 1'h0;
      if (wrd === 1'h1) pw = 1'h0;
      aw <= pa;
      wv <= pw;
    end
    while (bv !== 1'h1) @(posedge clk);
    br <= 1'h1;
    @(posedge clk);
    bq = bp;
    br <= 1'h0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    ra <= a;
    ar <= 1'h1;
    @(posedge clk);
    while (arr !== 1'h1) @(posedge clk);
    ar <= 1'h0;
    while (rv !== 1'h1) @(posedge clk);
    rr <= 1'h1;
    @(posedge clk);
    d = rdat[7:0];
    r = rp;
    rr <= 1'h0;
  end
  endtask
  task t_config;
    logic [7:0] m;
  begin
    for (int b = 0; b < 5; b++)
    begin
      m = (b == 3) ? 8'h1F : 8'hFF;
      wr(adr(b, 0), 8'hA5);
      wr(adr(b, 1), 8'h3C);
      wr(adr(b, 2), 8'h5A);
      chk(bq, 2'h0);
      rd(adr(b, 1));
      chk(r, 2'h0);
      chk(d, 8'h3C & m);
      chk({poe[b*8+:8], po[b*8+:8], ppu[b*8+:8]}, {8'h3C & m, 8'h24 & m, 8'h5A & m});
    end
    wr(8'hA0, 8'hFF);
    chk(bq, 2'h2);
    ws <= 4'hE;
    wr(adr(2, 0), 8'h00);
    ws <= 4'hF;
    rd(adr(2, 0));
    chk(d, 8'hA5);
    rd(8'h70);
    chk(d & 8'hE0, 8'h0);
    rd(8'h30);
    chk(d & 8'h20, 8'h0);
    rd(8'hA0);
    chk(r, 2'h2);
  end
  endtask
  // Cases: bank, pin, mask; bank 2 must stay silent
  task t_irq;
    logic [15:0] cs [5] = '{16'h0001, 16'h0101, 16'h1102, 16'h4780, 16'h20FF};
    int b, k;
  begin
    for (int i = 0; i < 5; i++)
    begin
      b = cs[i][15:12];
      k = cs[i][11:8];
      wr(adr(b, 5), cs[i][7:0]);
      rd(adr(b, 6));
      ev[b*8+k] <= ~ev[b*8+k];
      repeat (8) @(posedge clk);
      chk(irq, b != 2 && cs[i][k]);
      rd(adr(b, 6));
      chk(d, (b == 2) ? 8'h0 : 8'h1 << k);
      chk(irq, 1'h0);
      wr(adr(b, 5), 8'h0);
    end
  end
  endtask
  task t_od;
  begin
    wr(adr(0, 3), 8'hFF);
    wr(adr(0, 1), 8'hFF);
    wr(adr(0, 0), 8'h0F);
    chk(poe[7:0], 8'hF0);
    chk(po[7:0], 8'h00);
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk({poe, po}, {40'h0000002000, 40'h0});
    chk({ppu, irq}, 41'h0);
    t_config;
    t_irq;
    t_od;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
